// >>> rtl/psm_pkg.sv
// Operation
// - Report each window's largest magnitude, 13 bits
// - Window length: shared 24-bit sample period
// - Peak detection runs only while enabled
// - Software writes period before enabling detection
// - Enable loads period; timer counts output samples
// - Keep larger of sample and running peak
// - Window starts seeded with current sample magnitude
// - Count one copies peak into readable holding
// - Then reload timer and reseed running peak
// - Embedding needs both select bits and route bit
// - Control bits fill MSB first; monitor topmost
// - Software sets link control-bit routing
// - 25-bit frame, MSB first, five start-led subframes
// - Receiver rebuilds frames, checks start bits
// - Sample splits into two octets, tail last
// - Tail zero, pseudorandom, or status control bits
// - Lanes and converters per link configurable; fixed here at two converters over four lanes
// - K, word size, control count within range
// - Both ends share identical link parameters
// - Reset: converter A lanes 0-1, B lanes 2-3
// - Control bits below sample, then tail bits
`default_nettype none
package psm_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int SAMPLE_W   = 14;
  localparam int PEAK_W     = 13;
  localparam int PERIOD_W   = 24;
  localparam int OCTET_W    = 8;
  localparam int WORD_W     = 16;
  localparam int FRAME_W    = 25;
  localparam int SUB_W      = 5;
  localparam int SUB_N      = 5;
  localparam int NUM_CONV   = 2;
  localparam int NUM_LANES  = 4;
  localparam int FRAMES_MF  = 32;
  localparam int FIFO_DEPTH = 4;
  localparam int PRBS_W     = 15;

  // ----------------------------------------------------------------
  // Control bit homes and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_MON_CTRL    = 16'h0270;
  localparam int          MON_PEAK_EN_BIT  = 1;
  localparam logic [15:0] ADDR_EMBED_SEL   = 16'h0279;
  localparam logic [1:0]  EMBED_SEL_ON     = 2'h3;
  localparam logic [15:0] ADDR_EMBED_ROUTE = 16'h027A;
  localparam int          EMBED_ROUTE_BIT  = 1;
  localparam logic [15:0] ADDR_LINK_CS0    = 16'h0559;
  localparam logic [15:0] ADDR_LINK_CS1    = 16'h055A;
  localparam logic [15:0] ADDR_LINK_CS2    = 16'h058F;
  localparam logic [12:0] PEAK_MAX         = 13'h1FFF;
  localparam logic [14:0] PRBS_SEED        = 15'h7FFF;
  localparam logic [4:0]  FRAME_LEFT       = 5'h18;

  typedef enum logic {
    PSM_TAIL_ZERO = 1'b0,
    PSM_TAIL_PRBS = 1'b1
  } psm_tail_e;

  typedef enum logic {
    PSM_RX_HUNT = 1'b0,
    PSM_RX_TAKE = 1'b1
  } psm_rxst_e;

endpackage
`default_nettype wire

// >>> rtl/psm_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface psm_link_if;
  logic [7:0] lane0_output;
  logic [7:0] lane1_output;
  logic [7:0] lane2_output;
  logic [7:0] lane3_output;
  logic       frame_valid;
  logic       frame_ready;

  modport tx (
    output lane0_output, lane1_output, lane2_output, lane3_output,
    output frame_valid,
    input  frame_ready
  );
  modport rx (
    input  lane0_output, lane1_output, lane2_output, lane3_output,
    input  frame_valid,
    output frame_ready
  );
endinterface
`default_nettype wire

// >>> rtl/psm_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module psm_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_i,      // Clock
  input  wire logic             arst_n_i,   // Async reset, low
  input  wire logic             in_valid_i, // Write offered
  input  wire logic [WIDTH-1:0] in_data_i,  // Write word
  output logic                  in_ready_o, // Room left
  output logic                  out_valid_o,// Word held
  output logic      [WIDTH-1:0] out_data_o, // Held word
  input  wire logic             out_ready_i // Drain takes
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               rd;
    logic [AW-1:0]               wr;
    logic [CW-1:0]               cnt;
    logic                        ov;
    logic [WIDTH-1:0]            od;
    logic                        ir;
  } psm_fifo_s;

  localparam psm_fifo_s FIFO_RST = '{mem: '0, rd: '0, wr: '0, cnt: '0,
                                     ov: 1'b0, od: '0, ir: 1'b1};

  psm_fifo_s r;
  psm_fifo_s next_r;

  // ----------------------------------------------------------------
  // Storage, output stage and occupancy
  // ----------------------------------------------------------------
  // Output stage refills from storage first, else straight from input
  always_comb begin
    logic take;
    logic push;
    logic memw;
    logic pop;
    next_r = r;
    take = r.ov & out_ready_i;
    push = in_valid_i & r.ir;
    memw = push;
    pop  = 1'b0;
    if (!r.ov || take) begin
      if (r.cnt != '0) begin
        next_r.od = r.mem[r.rd];
        next_r.rd = r.rd + AW'(1);
        next_r.ov = 1'b1;
        pop = 1'b1;
      end else if (push) begin
        next_r.od = in_data_i;
        next_r.ov = 1'b1;
        memw = 1'b0;
      end else begin
        next_r.ov = 1'b0;
      end
    end
    if (memw) begin
      next_r.mem[r.wr] = in_data_i;
      next_r.wr = r.wr + AW'(1);
    end
    next_r.cnt = r.cnt + CW'(memw) - CW'(pop);
    next_r.ir  = (next_r.cnt < CW'(DEPTH));
  end

  // State register
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      r <= FIFO_RST;
    end else begin
      r <= next_r;
    end
  end

  assign in_ready_o  = r.ir;
  assign out_valid_o = r.ov;
  assign out_data_o  = r.od;
endmodule // psm_fifo
`default_nettype wire

// >>> rtl/psm_tx.sv
`timescale 1ns/100ps
`default_nettype none
module psm_tx #(
  parameter int LANES = psm_pkg::NUM_LANES,
  parameter int CONVS = psm_pkg::NUM_CONV,
  parameter int KMF   = psm_pkg::FRAMES_MF,
  parameter int NP    = psm_pkg::WORD_W,
  parameter int DEPTH = psm_pkg::FIFO_DEPTH
) (
  input  wire logic              clk_i,          // Sample clock
  input  wire logic              arst_n_i,       // Async reset, low
  input  wire logic              sample_valid_i, // Decimated sample
  input  wire logic [13:0]       sample_a_i,     // Converter A
  input  wire logic [13:0]       sample_b_i,     // Converter B
  output logic                   sample_ready_o, // Path can take
  input  wire logic [23:0]       period_i,       // Monitor period value
  input  wire logic              peak_enable_i,  // Detection on
  input  wire logic [1:0]        embed_sel_i,    // Embed select bits
  input  wire logic              embed_route_i,  // Embed route bit
  input  wire logic [1:0]        cs_i,           // Control bits/sample
  input  wire psm_pkg::psm_tail_e tail_mode_i,   // Tail filling
  input  wire logic [1:0]        over_range_i,   // Overrange per conv
  input  wire logic              sysref_cap_i,   // Sync capture seen
  input  wire logic [1:0]        fast_det_i,     // Fast detect per conv
  output logic [1:0][12:0]       peak_hold_o,    // Holding registers
  output logic                   peak_update_o,  // Holding refreshed
  psm_link_if.tx                 link            // Lane side
);
  typedef struct packed {
    logic [23:0]       timer;
    logic              active;
    logic              seed;
    logic [1:0][12:0]  store;
    logic [1:0][12:0]  hold;
    logic              upd;
    logic [1:0][24:0]  sh;
    logic [1:0][4:0]   left;
    logic [1:0]        pend;
    logic [14:0]       prbs;
  } psm_tx_s;

  localparam psm_tx_s TX_RST = '{timer: '0, active: 1'b0, seed: 1'b0,
                                 store: '0, hold: '0, upd: 1'b0,
                                 sh: '0, left: '0, pend: '0,
                                 prbs: psm_pkg::PRBS_SEED};

  psm_tx_s     r;
  psm_tx_s     next_r;
  logic [31:0] fifo_in;
  logic [31:0] fifo_out;
  logic        take;
  logic        embed_on;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Saturated absolute value; the most negative code maps to the top
  function automatic logic [12:0] psm_mag(input logic [13:0] s);
    logic [13:0] a;
    a = s[13] ? 14'(-s) : s;
    return a[13] ? psm_pkg::PEAK_MAX : a[12:0];
  endfunction

  // Five subframes, each a start bit and four data bits
  function automatic logic [24:0] psm_frame(input logic [12:0] h);
    logic [19:0] d;
    logic [24:0] f;
    d = {7'h00, h};
    f = '0;
    for (int i = 0; i < psm_pkg::SUB_N; i++) begin
      f[24 - 5*i -: 5] = {1'b1, d[19 - 4*i -: 4]};
    end
    return f;
  endfunction

  // ----------------------------------------------------------------
  // Sample acceptance and link word build
  // ----------------------------------------------------------------
  // A sample counts only when the buffer can take its word
  assign take     = sample_valid_i & sample_ready_o;
  assign embed_on = (embed_sel_i == psm_pkg::EMBED_SEL_ON) & embed_route_i;

  // Sample on top, control bits next, tail bits at the bottom
  always_comb begin
    logic [1:0][13:0] smp;
    logic [1:0][1:0]  low;
    logic [3:0]       src;
    logic [1:0]       tail;
    smp  = {sample_b_i, sample_a_i};
    low  = '0;
    src  = '0;
    tail = (tail_mode_i == psm_pkg::PSM_TAIL_PRBS) ? r.prbs[1:0] : 2'h0;
    for (int c = 0; c < 2; c++) begin
      // Monitor stream takes the topmost control slot when embedded
      if (embed_on) begin
        src = {(r.left[c] != '0) ? r.sh[c][24] :
               (r.pend[c] ? 1'b1 : 1'b0),
               over_range_i[c], sysref_cap_i, fast_det_i[c]};
      end else begin
        src = {over_range_i[c], sysref_cap_i, fast_det_i[c], 1'b0};
      end
      // Two free bits below a 14-bit sample; a third slot has no room
      low[c][1] = (cs_i != 2'h0) ? src[3] : tail[1];
      low[c][0] = (cs_i >= 2'h2) ? src[2] : tail[0];
    end
    // Converter A feeds lanes 0 and 1, converter B lanes 2 and 3
    fifo_in = {smp[0][13:6], smp[0][5:0], low[0],
               smp[1][13:6], smp[1][5:0], low[1]};
  end

  // ----------------------------------------------------------------
  // Peak detector, period timer and serializer
  // ----------------------------------------------------------------
  // Timer is shared by both channels; each has its own peak store
  always_comb begin
    logic [1:0][12:0] m;
    logic [1:0][12:0] pk;
    logic             last;
    logic [24:0]      fr;
    next_r = r;
    next_r.upd = 1'b0;
    fr = '0;
    m  = {psm_mag(sample_b_i), psm_mag(sample_a_i)};
    pk = '0;
    last = (r.timer <= 24'h000001);
    if (!peak_enable_i) begin
      next_r.active = 1'b0;
    end else if (!r.active) begin
      next_r.active = 1'b1;
      next_r.timer  = period_i;
      next_r.seed   = 1'b1;
    end else if (take) begin
      for (int c = 0; c < 2; c++) begin
        pk[c] = (r.seed || m[c] > r.store[c]) ? m[c] : r.store[c];
        next_r.store[c] = pk[c];
      end
      if (last) begin
        next_r.hold  = pk;
        next_r.upd   = 1'b1;
        next_r.timer = period_i;
        next_r.seed  = 1'b1;
      end else begin
        next_r.timer = r.timer - 24'h000001;
        next_r.seed  = 1'b0;
      end
    end
    // One frame bit leaves per accepted sample, MSB first
    for (int c = 0; c < 2; c++) begin
      if (!embed_on) begin
        next_r.left[c] = '0;
        next_r.pend[c] = 1'b0;
      end else if (take) begin
        if (r.left[c] != '0) begin
          next_r.sh[c]   = {r.sh[c][23:0], 1'b0};
          next_r.left[c] = r.left[c] - 5'h01;
        end else if (r.pend[c]) begin
          fr             = psm_frame(r.hold[c]);
          next_r.sh[c]   = {fr[23:0], 1'b0};
          next_r.left[c] = psm_pkg::FRAME_LEFT;
          next_r.pend[c] = 1'b0;
        end
      end
      // A fresh result queues its frame; set wins over the clear
      if (embed_on && next_r.upd) begin
        next_r.pend[c] = 1'b1;
      end
    end
    // Pseudorandom tail source, x^15 + x^14 + 1
    if (take) begin
      next_r.prbs = {r.prbs[13:0], r.prbs[14] ^ r.prbs[13]};
    end
  end

  // Loading the first frame bit is done one stage early: a pending
  // frame sends its start bit on the same sample that loads it
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      r <= TX_RST;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Buffer toward the link
  // ----------------------------------------------------------------
  // Link back-pressure stalls sample acceptance through the buffer
  psm_fifo #(
    .WIDTH (32),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .arst_n_i    (arst_n_i),
    .in_valid_i  (sample_valid_i),
    .in_data_i   (fifo_in),
    .in_ready_o  (sample_ready_o),
    .out_valid_o (link.frame_valid),
    .out_data_o  (fifo_out),
    .out_ready_i (link.frame_ready)
  );

  // Lane mapping for two converters over four lanes
  assign link.lane0_output = fifo_out[31:24];
  assign link.lane1_output = fifo_out[23:16];
  assign link.lane2_output = fifo_out[15:8];
  assign link.lane3_output = fifo_out[7:0];

  // Results straight from the state register
  assign peak_hold_o   = r.hold;
  assign peak_update_o = r.upd;
endmodule // psm_tx
`default_nettype wire

// >>> rtl/psm_rx.sv
`timescale 1ns/100ps
`default_nettype none
module psm_rx #(
  parameter int LANES = psm_pkg::NUM_LANES,
  parameter int CONVS = psm_pkg::NUM_CONV,
  parameter int NP    = psm_pkg::WORD_W
) (
  input  wire logic        clk_i,          // Clock
  input  wire logic        arst_n_i,       // Async reset, low
  psm_link_if.rx           link,           // Lane side
  input  wire logic        ready_i,        // User can take
  input  wire logic [1:0]  cs_i,           // Control bits/sample
  input  wire logic        embed_on_i,     // Monitor embedded
  output logic [1:0][13:0] samples_o,      // Rebuilt samples
  output logic [1:0][1:0]  low_bits_o,     // Control/tail bits
  output logic             sample_valid_o, // New samples pulse
  output logic [1:0][12:0] peak_o,         // Rebuilt peaks
  output logic [1:0]       peak_valid_o,   // New peak pulse
  output logic [1:0]       frame_err_o     // Bad start bit pulse
);
  typedef struct packed {
    logic                         rdy;
    logic                         sv;
    logic [1:0][13:0]             smp;
    logic [1:0][1:0]              low;
    psm_pkg::psm_rxst_e [1:0]     st;
    logic [1:0][4:0]              left;
    logic [1:0][23:0]             sh;
    logic [1:0][12:0]             pk;
    logic [1:0]                   pv;
    logic [1:0]                   fe;
  } psm_rx_s;

  psm_rx_s r;
  psm_rx_s next_r;

  // ----------------------------------------------------------------
  // Word split and frame rebuild
  // ----------------------------------------------------------------
  // Hunt for a start bit, gather 24 more, then check subframes
  always_comb begin
    logic [1:0][15:0] w;
    logic [24:0]      f;
    logic [19:0]      d;
    logic             ok;
    next_r    = r;
    next_r.rdy = ready_i;
    next_r.sv = 1'b0;
    next_r.pv = '0;
    next_r.fe = '0;
    w = {link.lane2_output, link.lane3_output,
         link.lane0_output, link.lane1_output};
    f  = '0;
    d  = '0;
    ok = 1'b0;
    if (link.frame_valid && r.rdy) begin
      next_r.sv = 1'b1;
      for (int c = 0; c < 2; c++) begin
        next_r.smp[c] = w[c][15:2];
        next_r.low[c] = w[c][1:0];
        if (embed_on_i && cs_i != 2'h0) begin
          unique case (r.st[c])
            psm_pkg::PSM_RX_HUNT: begin
              if (w[c][1]) begin
                next_r.sh[c]   = 24'h000001;
                next_r.left[c] = psm_pkg::FRAME_LEFT;
                next_r.st[c]   = psm_pkg::PSM_RX_TAKE;
              end
            end
            psm_pkg::PSM_RX_TAKE: begin
              next_r.sh[c]   = {r.sh[c][22:0], w[c][1]};
              next_r.left[c] = r.left[c] - 5'h01;
              if (r.left[c] == 5'h01) begin
                f  = {r.sh[c], w[c][1]};
                ok = 1'b1;
                for (int i = 0; i < psm_pkg::SUB_N; i++) begin
                  ok = ok & f[24 - 5*i];
                  d[19 - 4*i -: 4] = f[23 - 5*i -: 4];
                end
                if (ok) begin
                  next_r.pk[c] = d[12:0];
                  next_r.pv[c] = 1'b1;
                end else begin
                  next_r.fe[c] = 1'b1;
                end
                next_r.st[c] = psm_pkg::PSM_RX_HUNT;
              end
            end
          endcase
        end else begin
          next_r.st[c] = psm_pkg::PSM_RX_HUNT;
        end
      end
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign link.frame_ready = r.rdy;
  assign samples_o        = r.smp;
  assign low_bits_o       = r.low;
  assign sample_valid_o   = r.sv;
  assign peak_o           = r.pk;
  assign peak_valid_o     = r.pv;
  assign frame_err_o      = r.fe;
endmodule // psm_rx
`default_nettype wire

// >>> sim/psm_link_chk.sv
`timescale 1ns/100ps
`default_nettype none
module psm_link_chk (
  input wire logic               clk_i,        // Clock
  input wire logic               arst_n_i,     // Async reset, low
  input wire logic [7:0]         lane0_output, // Lane 0
  input wire logic [7:0]         lane1_output, // Lane 1
  input wire logic [7:0]         lane2_output, // Lane 2
  input wire logic [7:0]         lane3_output, // Lane 3
  input wire logic               frame_valid,  // Word offered
  input wire logic               frame_ready,  // Word taken
  input wire logic               embed_on_i,   // Monitor embedded
  input wire logic [1:0]         cs_i,         // Control bits
  input wire psm_pkg::psm_tail_e tail_mode_i   // Tail fill
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  logic            take;
  logic [1:0]      mbit;
  logic [1:0][4:0] pos;
  logic [1:0][4:0] next_pos;

  // Accepted word and monitor bit per channel
  assign take = frame_valid && frame_ready;
  assign mbit = {lane3_output[1], lane1_output[1]};

  // Bit index inside a monitor frame, 0 while hunting
  always_comb begin
    next_pos = pos;
    for (int c = 0; c < 2; c++) begin
      if (take && embed_on_i && cs_i != 2'h0) begin
        if (pos[c] != 5'h00) next_pos[c] = (pos[c] == 5'h18) ? 5'h00 : pos[c] + 5'h01;
        else if (mbit[c]) next_pos[c] = 5'h01;
      end
    end
  end

  // Frame position register
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) pos <= '0;
    else pos <= next_pos;
  end

  sequence stall_s;
    frame_valid && !frame_ready;
  endsequence

  valid_hold_a: assert property (stall_s |=> frame_valid)
    else $error("link word withdrawn while stalled");
  word_hold_a: assert property (stall_s |=> $stable({lane0_output, lane1_output,
    lane2_output, lane3_output}))
    else $error("link word changed while stalled");
  reset_idle_a: assert property ($rose(arst_n_i) |-> !frame_valid
    && {lane0_output, lane1_output, lane2_output, lane3_output} == 32'h0)
    else $error("link not idle after reset");
  tail_zero_a: assert property (take && cs_i == 2'h0 && tail_mode_i ==
    psm_pkg::PSM_TAIL_ZERO |-> {lane1_output[1:0], lane3_output[1:0]} == 4'h0)
    else $error("tail bits not zero");
  a_start_bit_a: assert property (take && pos[0] inside {5'h05, 5'h0A, 5'h0F, 5'h14}
    |-> mbit[0])
    else $error("missing start bit on channel A");
  b_start_bit_a: assert property (take && pos[1] inside {5'h05, 5'h0A, 5'h0F, 5'h14}
    |-> mbit[1])
    else $error("missing start bit on channel B");
  a_frame_pad_a: assert property (take && pos[0] inside {[5'h01:5'h04], [5'h06:5'h08]}
    |-> !mbit[0])
    else $error("frame padding not zero on channel A");
  b_frame_pad_a: assert property (take && pos[1] inside {[5'h01:5'h04], [5'h06:5'h08]}
    |-> !mbit[1])
    else $error("frame padding not zero on channel B");
endmodule // psm_link_chk
`default_nettype wire

// >>> sim/test_peak_signal_monitor_ctrl_bits.sv
`timescale 1ns/100ps
`default_nettype none
module test_peak_signal_monitor_ctrl_bits;
  logic clk_i = 0, arst_n_i = 0, sample_valid_i = 0, peak_enable_i = 0;
  logic [13:0] sample_a_i = 0, sample_b_i = 0;
  logic [23:0] period_i = 0;
  logic [1:0] embed_sel_i = 0, cs_i = 0, over_range_i = 0, fast_det_i = 2'h3;
  logic embed_route_i = 0, sysref_cap_i = 0, ready_i = 1, sample_ready_o, peak_update_o;
  psm_pkg::psm_tail_e tail_mode_i = psm_pkg::PSM_TAIL_ZERO;
  logic [1:0][12:0] peak_hold_o, peak_o;
  logic [1:0][13:0] samples_o;
  logic [1:0] peak_valid_o, frame_err_o;
  logic [1:0][1:0] low_bits_o;
  logic rx_valid, chk_low = 0;
  logic [3:0] exp_low = 0;
  logic [12:0] exp_pa = 0, exp_pb = 0, pa, pb;
  logic [27:0] qw[$], qs[$];
  int n_errors = 0, n_checks = 0, n_upd = 0, n_pk = 0, n_tail = 0, n;
  logic [13:0] wa[12] = '{14'h3FFB, 14'h0064, 14'h0007, 14'h3448, 14'h000A, 14'h0003,
                          14'h0002, 14'h0001, 14'h0005, 14'h0000, 14'h0100, 14'h2000};

  psm_link_if lnk ();

  psm_tx u_psm_tx (.clk_i(clk_i), .arst_n_i(arst_n_i), .sample_valid_i(sample_valid_i),
    .sample_a_i(sample_a_i), .sample_b_i(sample_b_i), .sample_ready_o(sample_ready_o),
    .period_i(period_i), .peak_enable_i(peak_enable_i), .embed_sel_i(embed_sel_i),
    .embed_route_i(embed_route_i), .cs_i(cs_i), .tail_mode_i(tail_mode_i),
    .over_range_i(over_range_i), .sysref_cap_i(sysref_cap_i), .fast_det_i(fast_det_i),
    .peak_hold_o(peak_hold_o), .peak_update_o(peak_update_o), .link(lnk.tx));

  psm_rx u_psm_rx (.clk_i(clk_i), .arst_n_i(arst_n_i), .link(lnk.rx), .ready_i(ready_i),
    .cs_i(cs_i), .embed_on_i(embed_sel_i == 2'h3 && embed_route_i), .samples_o(samples_o),
    .low_bits_o(low_bits_o), .sample_valid_o(rx_valid), .peak_o(peak_o),
    .peak_valid_o(peak_valid_o), .frame_err_o(frame_err_o));

  psm_link_chk u_psm_link_chk (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .lane0_output(lnk.lane0_output), .lane1_output(lnk.lane1_output),
    .lane2_output(lnk.lane2_output), .lane3_output(lnk.lane3_output),
    .frame_valid(lnk.frame_valid), .frame_ready(lnk.frame_ready),
    .embed_on_i(embed_sel_i == 2'h3 && embed_route_i), .cs_i(cs_i),
    .tail_mode_i(tail_mode_i));

  // Clock of 100 ns
  always #50 clk_i = ~clk_i;

  task automatic check(input string what, input logic [27:0] exp, input logic [27:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Saturated magnitude of a two's complement sample
  function automatic logic [12:0] mag(input logic [13:0] s);
    logic [13:0] m;
    m = s[13] ? (~s + 14'h0001) : s;
    return (m > 14'h1FFF) ? 13'h1FFF : m[12:0];
  endfunction

  // Offer one sample pair and hold it until taken
  task automatic put(input logic [13:0] a, input logic [13:0] b);
    int k;
    k = 0;
    sample_valid_i <= 1'b1;
    sample_a_i <= a;
    sample_b_i <= b;
    do begin
      @(posedge clk_i);
      k++;
    end while (sample_ready_o !== 1'b1 && k < 50);
    if (k >= 50) check("sample accept", 28'h1, 28'h0);
    qw.push_back({a, b});
    qs.push_back({a, b});
  endtask

  task automatic idle(input int c);
    sample_valid_i <= 1'b0;
    repeat (c) @(posedge clk_i);
  endtask

  // Link and receiver observer
  always @(posedge clk_i) begin
    if (lnk.frame_valid === 1'b1 && lnk.frame_ready === 1'b1) begin
      check("lanes", qw.pop_front(), {lnk.lane0_output, lnk.lane1_output[7:2],
        lnk.lane2_output, lnk.lane3_output[7:2]});
      if (chk_low) check("low bits", 28'(exp_low), 28'({lnk.lane1_output[1:0],
        lnk.lane3_output[1:0]}));
      if (lnk.lane1_output[1:0] != 2'h0) n_tail++;
    end
    if (rx_valid === 1'b1) check("rx samples", qs.pop_front(), {samples_o[0], samples_o[1]});
    if (peak_valid_o[0] === 1'b1) begin
      n_pk++;
      check("rx peak a", 28'(exp_pa), 28'(peak_o[0]));
    end
    if (peak_valid_o[1] === 1'b1) begin
      n_pk++;
      check("rx peak b", 28'(exp_pb), 28'(peak_o[1]));
    end
    if (rx_valid === 1'b1 && chk_low) check("rx low bits", 28'(exp_low),
      28'({low_bits_o[0], low_bits_o[1]}));
    if (frame_err_o !== 2'h0) check("frame error", 28'h0, 28'(frame_err_o));
    if (peak_update_o === 1'b1) n_upd++;
  end

  // Watchdog
  initial begin
    #3000000;
    n_errors++;
    finish_test;
  end

  // Main sequence
  initial begin
    repeat (8) @(posedge clk_i);
    check("hold at reset", 28'h0, 28'(peak_hold_o));
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    // Three windows of four samples, period written first
    period_i <= 24'h000004;
    @(posedge clk_i);
    peak_enable_i <= 1'b1;
    @(posedge clk_i);
    for (int w = 0; w < 3; w++) begin
      pa = 0;
      pb = 0;
      for (int i = 0; i < 4; i++) begin
        put(wa[w*4+i], ~wa[w*4+i]);
        pa = (mag(wa[w*4+i]) > pa) ? mag(wa[w*4+i]) : pa;
        pb = (mag(~wa[w*4+i]) > pb) ? mag(~wa[w*4+i]) : pb;
      end
      sample_valid_i <= 1'b0;
      n = 0;
      while (peak_update_o !== 1'b1 && n < 20) begin
        @(posedge clk_i);
        n++;
      end
      check("hold a", 28'(pa), 28'(peak_hold_o[0]));
      check("hold b", 28'(pb), 28'(peak_hold_o[1]));
    end
    @(posedge clk_i);
    check("updates", 28'h3, 28'(n_upd));
    // Detection off: no window may close
    peak_enable_i <= 1'b0;
    for (int i = 0; i < 8; i++) put(14'h0040, 14'h0041);
    idle(10);
    check("updates off", 28'h3, 28'(n_upd));
    // Stalled receiver fills the buffer, then drains it
    ready_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    n = 0;
    sample_valid_i <= 1'b1;
    sample_a_i <= 14'h0100;
    sample_b_i <= 14'h0200;
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_i);
      if (sample_ready_o === 1'b1) begin
        qw.push_back({sample_a_i, sample_b_i});
        qs.push_back({sample_a_i, sample_b_i});
        n++;
        sample_a_i <= sample_a_i + 14'h0001;
      end
    end
    sample_valid_i <= 1'b0;
    check("fill count", 28'h5, 28'(n));
    ready_i <= 1'b1;
    idle(20);
    check("drained", 28'h0, 28'(qw.size() + qs.size()));
    // Control bit counts with status sources
    embed_sel_i <= 2'h1;
    embed_route_i <= 1'b1;
    over_range_i <= 2'h1;
    sysref_cap_i <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      cs_i <= 2'(c);
      exp_low <= (c == 0) ? 4'h0 : (c == 1) ? 4'h8 : 4'hD;
      chk_low <= 1'b1;
      for (int i = 0; i < 3; i++) put(14'(c), 14'h1234);
      idle(10);
    end
    chk_low <= 1'b0;
    // Pseudorandom tail
    cs_i <= 2'h0;
    tail_mode_i <= psm_pkg::PSM_TAIL_PRBS;
    n_tail = 0;
    for (int i = 0; i < 8; i++) put(14'h0011, 14'h0022);
    idle(10);
    check("prbs tail", 28'h1, 28'(n_tail > 0));
    // Monitor stream, first embedded, then select bits incomplete
    tail_mode_i <= psm_pkg::PSM_TAIL_ZERO;
    over_range_i <= 2'h0;
    cs_i <= 2'h1;
    period_i <= 24'h00001E;
    exp_pa <= 13'h0ABC;
    exp_pb <= 13'h0100;
    @(posedge clk_i);
    for (int e = 1; e >= 0; e--) begin
      embed_sel_i <= (e == 1) ? 2'h3 : 2'h1;
      exp_low <= 4'h0;
      chk_low <= (e == 0);
      peak_enable_i <= 1'b1;
      for (int j = 0; j < 57; j++)
        put((j == 7) ? 14'h0ABC : 14'h0010, (j == 7) ? 14'h3F00 : 14'h0020);
      idle(5);
      check("rx peak count", 28'h2, 28'(n_pk));
      peak_enable_i <= 1'b0;
      @(posedge clk_i);
    end
    finish_test;
  end
endmodule // test_peak_signal_monitor_ctrl_bits
`default_nettype wire
